//--- lp2_ca_capture.sv
// Pin capture of one command frame: both halves of the command/address bits, chip select and CKE
`timescale 1ns/1ps
`default_nettype none

module lp2_ca_capture
  import lp2_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       cke,
  input  wire logic       cs_n,
  input  wire logic [9:0] ca,
  output lp2_frame_t      frame
);

  logic       cke_cur_r;   // CKE at the latest rising edge
  logic       cke_prev_r;  // CKE at the rising edge before
  logic       cs_n_r;      // Chip select at the latest rising edge
  logic [9:0] ca_rise_r;   // First half of the command
  logic [9:0] ca_fall_r;   // Second half of the command

  // Rising edge: select, CKE and the first half only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cke_cur_r  <= 1'b0;
      cke_prev_r <= 1'b0;
      cs_n_r     <= 1'b1;
      ca_rise_r  <= 10'h000;
    end else begin
      cke_cur_r  <= cke;
      cke_prev_r <= cke_cur_r;
      cs_n_r     <= cs_n;
      ca_rise_r  <= ca;
    end
  end

  // Falling edge: second half; select and CKE are never looked at here
  always_ff @(negedge clk) begin
    if (sys_rst) begin
      ca_fall_r <= 10'h000;
    end else begin
      ca_fall_r <= ca;
    end
  end

  // Frame is complete from the falling edge until the next rising edge
  assign frame = '{cke_prev: cke_prev_r, cke_cur: cke_cur_r, cs_n: cs_n_r,
                   ca_rise: ca_rise_r, ca_fall: ca_fall_r};

endmodule : lp2_ca_capture

`default_nettype wire

//--- lp2_cmd_fsm.sv
// Command decoder, per-bank state machines and global power state of the memory die
`timescale 1ns/1ps
`default_nettype none

`include "lp2_params.svh"

module lp2_cmd_fsm
  import lp2_pkg::*;
#(
  parameter int NUM_BANKS  = `LP2_NUM_BANKS,
  parameter int TRP_CYC    = `LP2_NS_TO_CYC(`LP2_T_RP_NS),
  parameter int TRFCPB_CYC = `LP2_NS_TO_CYC(`LP2_T_RFCPB_NS),
  parameter int TRFCAB_CYC = `LP2_NS_TO_CYC(`LP2_T_RFCAB_NS),
  parameter int TMRW_CYC   = `LP2_NS_TO_CYC(`LP2_T_MRW_NS),
  parameter int TMRR_CYC   = `LP2_NS_TO_CYC(`LP2_T_MRR_NS),
  parameter int TINIT5_CYC = `LP2_NS_TO_CYC(`LP2_T_INIT5_NS),
  parameter int BURST_CYC  = `LP2_BURST_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        cke,
  input  wire logic                        cs_n,
  input  wire logic [9:0]                  ca,
  output lp2_pw_t                          pw_state,
  output lp2_bank_t [NUM_BANKS-1:0]        bank_state,
  output lp2_cmd_info_t                    cmd_evt,
  output logic                             all_idle,
  output logic                             init_done
);

  lp2_frame_t    fr;              // Captured frame
  lp2_cmd_info_t dec;             // Decoded command of that frame
  logic [3:0]    pat;             // CA0..CA3 in table order
  lp2_pw_t       pw_state_r;      // Global power state
  lp2_cmd_info_t cmd_evt_r;       // Registered command report
  logic          all_idle_r;      // Registered all-idle flag
  logic          init_done_r;     // Final init wait has run out
  logic [15:0]   init_cnt_r;      // Final init wait counter
  logic          cke_s1_r;        // Clockless exit path, first stage
  logic          cke_s2_r;        // Clockless exit path, second stage
  logic [2:0]    last_rw_bank_r;  // Bank of the latest burst
  logic          all_idle_c;      // Every bank idle now
  logic          go_c;            // A bank command may act
  logic          bank_clr_c;      // Banks held idle during init

  // Pin capture; the falling half comes in by its own edge
  lp2_ca_capture u_capture (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cke     (cke),
    .cs_n    (cs_n),
    .ca      (ca),
    .frame   (fr)
  );

  assign pat = {fr.ca_rise[0], fr.ca_rise[1], fr.ca_rise[2], fr.ca_rise[3]};

  // Field extraction and command decode from CKE pair, select, CA0-CA3
  always_comb begin
    dec       = '0;
    dec.code  = CMD_NONE;
    dec.bank  = fr.ca_rise[9:`LP2_BA_LSB];
    dec.ap    = fr.ca_fall[`LP2_AP_BIT];
    dec.ab    = fr.ca_rise[`LP2_AB_BIT];
    dec.row   = {fr.ca_fall[9:8], fr.ca_rise[6:2], fr.ca_fall[7:0]};
    dec.col   = {fr.ca_fall[9:1], fr.ca_rise[6:5], 1'b0};
    dec.ma    = {fr.ca_fall[1:0], fr.ca_rise[9:4]};
    dec.op    = fr.ca_fall[9:2];
    if (fr.cke_prev && fr.cke_cur) begin
      if (fr.cs_n) begin
        dec.code = CMD_NOP;
      end else begin
        unique casez (pat)
          4'b0000: dec.code = (dec.ma == `LP2_MA_RESET) ? CMD_RESET : CMD_MRW;
          4'b0001: dec.code = CMD_MRR;
          4'b0010: dec.code = CMD_REFPB;
          4'b0011: dec.code = CMD_REFAB;
          4'b01??: dec.code = CMD_ACT;
          4'b100?: dec.code = CMD_WR;
          4'b101?: dec.code = CMD_RD;
          4'b1100: dec.code = CMD_BST;
          4'b1101: dec.code = CMD_PRE;
          4'b111?: dec.code = CMD_NOP;
        endcase
      end
    end else if (fr.cke_prev && !fr.cke_cur) begin
      // CKE falling: power-down, self refresh or deep power-down entry
      if (fr.cs_n) begin
        dec.code = CMD_PDE;
      end else if (pat[3:1] == 3'b001) begin
        dec.code = CMD_SREF;
      end else if (pat[3:1] == 3'b110) begin
        dec.code = CMD_DPD;
      end
    end else if (!fr.cke_prev && fr.cke_cur && fr.cs_n) begin
      dec.code = CMD_EXIT;
    end
    dec.valid = (dec.code != CMD_NONE);
  end

  // Bank commands act only in normal operation; NOP has no branch below
  assign go_c       = (pw_state_r == PW_NORMAL) && dec.valid;
  assign bank_clr_c = (pw_state_r == PW_POWERON) || (pw_state_r == PW_RESETTING);

  // All-idle reduction over the bank states
  always_comb begin
    all_idle_c = 1'b1;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (bank_state[i] != BK_IDLE) begin
        all_idle_c = 1'b0;
      end
    end
  end

  // Clockless exit path: CKE resynchronised, first stage read by second only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cke_s1_r <= 1'b0;
      cke_s2_r <= 1'b0;
    end else begin
      cke_s1_r <= cke;
      cke_s2_r <= cke_s1_r;
    end
  end

  // Global power state; low-power states hold by default
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pw_state_r <= PW_POWERON;
    end else begin
      unique case (pw_state_r)
        PW_POWERON: begin
          if (dec.code == CMD_RESET) begin
            pw_state_r <= PW_RESETTING;
          end
        end
        PW_RESETTING: begin
          if (dec.code == CMD_PDE) begin
            pw_state_r <= PW_RPD;
          end else if (init_done_r) begin
            pw_state_r <= PW_NORMAL;
          end
        end
        PW_NORMAL: begin
          if (dec.code == CMD_PDE) begin
            pw_state_r <= all_idle_c ? PW_IPD : PW_APD;
          end else if (dec.code == CMD_SREF && all_idle_c) begin
            pw_state_r <= PW_SREF;
          end else if (dec.code == CMD_DPD && all_idle_c) begin
            pw_state_r <= PW_DPD;
          end else if (dec.code == CMD_RESET && all_idle_c) begin
            pw_state_r <= PW_RESETTING;
          end
        end
        // Exits need CKE rising with select high; low-low holds
        PW_APD, PW_IPD: begin
          if (dec.code == CMD_EXIT) begin
            pw_state_r <= PW_NORMAL;
          end
        end
        PW_RPD: begin
          if (dec.code == CMD_EXIT) begin
            pw_state_r <= init_done_r ? PW_NORMAL : PW_RESETTING;
          end
        end
        // Clockless exits: the level path, not the framed command
        PW_SREF: begin
          if (cke_s2_r) begin
            pw_state_r <= PW_NORMAL;
          end
        end
        PW_DPD: begin
          if (cke_s2_r) begin
            pw_state_r <= PW_POWERON;
          end
        end
      endcase
    end
  end

  // Final init wait; keeps running through resetting power-down
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      init_cnt_r  <= 16'h0000;
      init_done_r <= 1'b0;
    end else if (dec.code == CMD_RESET && (pw_state_r == PW_POWERON ||
                 (pw_state_r == PW_NORMAL && all_idle_c))) begin
      init_cnt_r  <= 16'(TINIT5_CYC);
      init_done_r <= 1'b0;
    end else if (pw_state_r == PW_DPD) begin
      // Deep power-down loses everything; full init again
      init_done_r <= 1'b0;
    end else if (init_cnt_r != 16'h0000) begin
      init_cnt_r  <= init_cnt_r - 16'h0001;
      init_done_r <= (init_cnt_r == 16'h0001);
    end
  end

  // Bank of the most recent burst, for burst terminate
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      last_rw_bank_r <= 3'h0;
    end else if (go_c && (dec.code == CMD_RD || dec.code == CMD_WR)) begin
      last_rw_bank_r <= dec.bank;
    end
  end

  // Registered command report and all-idle flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_evt_r  <= '0;
      all_idle_r <= 1'b1;
    end else begin
      cmd_evt_r  <= dec;
      all_idle_r <= all_idle_c;
    end
  end

  // Per-bank state machines; illegal commands for a state are ignored
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    lp2_bank_t st_r;   // Bank state
    logic [7:0] tmr_r; // Cycles left in a timed state
    logic       ap_r;  // Running burst closes with precharge
    logic       sel_c; // Command addresses this bank

    assign sel_c         = (dec.bank == 3'(b));
    assign bank_state[b] = st_r;

    always_ff @(posedge clk) begin
      if (sys_rst || bank_clr_c) begin
        st_r  <= BK_IDLE;
        tmr_r <= 8'h00;
        ap_r  <= 1'b0;
      end else begin
        tmr_r <= (tmr_r != 8'h00) ? tmr_r - 8'h01 : 8'h00;
        unique case (st_r)
          BK_IDLE: begin
            if (go_c && dec.code == CMD_ACT && sel_c) begin
              st_r <= BK_ACT;
            end else if (go_c && dec.code == CMD_REFPB && sel_c && NUM_BANKS == 8) begin
              st_r  <= BK_REF;
              tmr_r <= 8'(TRFCPB_CYC);
            end else if (go_c && dec.code == CMD_REFAB) begin
              st_r  <= BK_REF;
              tmr_r <= 8'(TRFCAB_CYC);
            end else if (go_c && dec.code == CMD_MRW) begin
              st_r  <= BK_MRW;
              tmr_r <= 8'(TMRW_CYC);
            end else if (go_c && dec.code == CMD_MRR) begin
              st_r  <= BK_MRRI;
              tmr_r <= 8'(TMRR_CYC);
            end else if (go_c && dec.code == CMD_PRE && (sel_c || dec.ab)) begin
              st_r  <= BK_PRE;
              tmr_r <= 8'(TRP_CYC);
            end
          end
          BK_ACT: begin
            if (go_c && (dec.code == CMD_RD || dec.code == CMD_WR) && sel_c) begin
              st_r  <= (dec.code == CMD_RD) ? BK_RD : BK_WR;
              ap_r  <= dec.ap;
              tmr_r <= 8'(BURST_CYC);
            end else if (go_c && dec.code == CMD_MRR) begin
              st_r  <= BK_MRRA;
              tmr_r <= 8'(TMRR_CYC);
            end else if (go_c && dec.code == CMD_PRE && (sel_c || dec.ab)) begin
              st_r  <= BK_PRE;
              tmr_r <= 8'(TRP_CYC);
            end
          end
          BK_RD, BK_WR: begin
            if (go_c && dec.code == CMD_BST && last_rw_bank_r == 3'(b)) begin
              st_r  <= BK_ACT;
              tmr_r <= 8'h00;
            end else if (go_c && (dec.code == CMD_RD || dec.code == CMD_WR) && sel_c) begin
              st_r  <= (dec.code == CMD_RD) ? BK_RD : BK_WR;
              ap_r  <= dec.ap;
              tmr_r <= 8'(BURST_CYC);
            end else if (tmr_r == 8'h01) begin
              // Burst done; auto precharge closes the row
              st_r  <= ap_r ? BK_PRE : BK_ACT;
              tmr_r <= ap_r ? 8'(TRP_CYC) : 8'h00;
            end
          end
          BK_PRE, BK_REF, BK_MRW, BK_MRRI: begin
            if (tmr_r == 8'h01) begin
              st_r <= BK_IDLE;
            end
          end
          BK_MRRA: begin
            if (tmr_r == 8'h01) begin
              st_r <= BK_ACT;
            end
          end
        endcase
      end
    end

    // Idle bank opens on its activate
    a_idle_act: assert property (@(posedge clk) disable iff (sys_rst)
      (go_c && dec.code == CMD_ACT && sel_c && st_r == BK_IDLE) |=> st_r == BK_ACT)
      else $error("idle bank missed its activate");

    // Auto-precharge burst closes after its two cycles; NOP traffic must not mask it
    sequence s_rd_ap_end;
      go_c && (dec.code == CMD_RD || dec.code == CMD_WR) && sel_c && dec.ap && st_r == BK_ACT && !bank_clr_c;
    endsequence
    a_rd_ap_pre: assert property (@(posedge clk) disable iff (sys_rst)
      s_rd_ap_end ##1 ((st_r == BK_RD || st_r == BK_WR) && !(dec.code inside {CMD_BST, CMD_RD, CMD_WR}))[*2]
      |=> st_r == BK_PRE)
      else $error("auto precharge did not follow burst");

    // Terminate lands on the latest burst bank
    a_bst_latest: assert property (@(posedge clk) disable iff (sys_rst)
      (go_c && dec.code == CMD_BST && last_rw_bank_r == 3'(b) && !bank_clr_c
       && (st_r == BK_RD || st_r == BK_WR)) |=> st_r == BK_ACT)
      else $error("burst terminate missed latest bank");
  end

  // Outputs from flip-flops
  assign pw_state  = pw_state_r;
  assign cmd_evt   = cmd_evt_r;
  assign all_idle  = all_idle_r;
  assign init_done = init_done_r;

  // Activate decode from the captured pins
  a_cmd_act: assert property (@(posedge clk) disable iff (sys_rst)
    (fr.cke_prev && fr.cke_cur && !fr.cs_n && fr.ca_rise[1:0] == 2'b10) |=> cmd_evt_r.code == CMD_ACT)
    else $error("activate not decoded");

  // Column from both halves, lowest bit zero
  a_col_halves: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd_evt_r.code == CMD_RD || cmd_evt_r.code == CMD_WR) |->
      cmd_evt_r.col == {$past(fr.ca_fall[9:1]), $past(fr.ca_rise[6:5]), 1'b0})
    else $error("column assembly wrong");

  // CKE low at both edges holds a low-power state
  a_cke_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (!fr.cke_prev && !fr.cke_cur && !(pw_state_r inside {PW_NORMAL, PW_POWERON, PW_RESETTING}))
      |=> $stable(pw_state_r))
    else $error("low-power state left with CKE low");

  // Power-down kind chosen by bank activity
  sequence s_pde_busy;
    pw_state_r == PW_NORMAL && dec.code == CMD_PDE && !all_idle_c;
  endsequence
  a_apd_entry: assert property (@(posedge clk) disable iff (sys_rst)
    s_pde_busy |=> pw_state_r == PW_APD ##1 (pw_state_r == PW_APD || pw_state_r == PW_NORMAL))
    else $error("active power-down not entered");

  // Self refresh entry when idle
  a_sref_entry: assert property (@(posedge clk) disable iff (sys_rst)
    (pw_state_r == PW_NORMAL && dec.code == CMD_SREF && all_idle_c) |=> pw_state_r == PW_SREF)
    else $error("self refresh not entered");

  // Self refresh leaves by the clockless path within three edges of CKE
  a_sref_exit: assert property (@(posedge clk) disable iff (sys_rst)
    (pw_state_r == PW_SREF && cke) ##1 cke[*2] |-> ##[0:1] pw_state_r == PW_NORMAL)
    else $error("self refresh exit late");

  // Deep power-down returns to power-on
  a_dpd_exit: assert property (@(posedge clk) disable iff (sys_rst)
    (pw_state_r == PW_DPD && cke_s2_r) |=> pw_state_r == PW_POWERON && !init_done_r)
    else $error("deep power-down exit wrong");

  // Resetting power-down exit follows the init wait
  a_rpd_exit: assert property (@(posedge clk) disable iff (sys_rst)
    (pw_state_r == PW_RPD && dec.code == CMD_EXIT) |=>
      pw_state_r == ($past(init_done_r) ? PW_NORMAL : PW_RESETTING))
    else $error("resetting power-down exit wrong");

endmodule : lp2_cmd_fsm

`default_nettype wire

//--- lp2_cmd_power_state_fsm_tb.sv
// Self-checking bench of the command decoder and power state machine
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module lp2_cmd_power_state_fsm_tb
  import lp2_pkg::*;
;
  // One table row: frame halves, bank watched, state, code, wait after
  typedef struct packed {
    logic [9:0] r;
    logic [9:0] f;
    logic [2:0] b;
    lp2_bank_t  s;
    lp2_cmd_t   c;
    logic [4:0] g;
  } lp2_row_t;
  logic                   clk;
  logic                   sys_rst;
  logic                   cke;
  logic                   cs_n;
  logic [9:0]             ca;
  lp2_pw_t                pw_state;
  lp2_bank_t [7:0]        bank_state;
  lp2_cmd_info_t          cmd_evt;
  logic                   all_idle;
  logic                   init_done;
  int                     fail_count = 0;
  int                     n_checks = 0;
  int                     cyc = 0;
  // Ordinary commands in normal state, the watched bank checked two edges on
  lp2_row_t rows [11] = '{
    '{10'h102, 10'h000, 3'd2, BK_ACT,  CMD_ACT,   5'd0},
    '{10'h165, 10'h3fe, 3'd2, BK_RD,   CMD_RD,    5'd0},
    '{10'h007, 10'h000, 3'd2, BK_ACT,  CMD_NOP,   5'd0},
    '{10'h101, 10'h001, 3'd2, BK_WR,   CMD_WR,    5'd0},
    '{10'h007, 10'h000, 3'd2, BK_PRE,  CMD_NOP,   5'd6},
    '{10'h282, 10'h000, 3'd5, BK_ACT,  CMD_ACT,   5'd0},
    '{10'h01b, 10'h000, 3'd5, BK_PRE,  CMD_PRE,   5'd6},
    '{10'h00c, 10'h000, 3'd0, BK_REF,  CMD_REFAB, 5'd25},
    '{10'h184, 10'h000, 3'd3, BK_REF,  CMD_REFPB, 5'd14},
    '{10'h008, 10'h000, 3'd1, BK_MRRI, CMD_MRR,   5'd4},
    '{10'h000, 10'h000, 3'd6, BK_MRW,  CMD_MRW,   5'd7}
  };
  // Small init wait so the resetting power-down exit lands before it ends
  lp2_cmd_fsm #(.TINIT5_CYC(40)) uut (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .cke        (cke),
    .cs_n       (cs_n),
    .ca         (ca),
    .pw_state   (pw_state),
    .bank_state (bank_state),
    .cmd_evt    (cmd_evt),
    .all_idle   (all_idle),
    .init_done  (init_done)
  );
  lp2_ctrl_model u_ctl (
    .clk  (clk),
    .cke  (cke),
    .cs_n (cs_n),
    .ca   (ca)
  );
  // Free-running clock, so exits always see it toggle
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      results();
    end
  end
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic results();
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  initial begin
    sys_rst = 1'b1;
    settle(4);
    sys_rst = 1'b0;
    `CHK("pw", PW_POWERON, pw_state)
    `CHK("idle", 1'b1, all_idle)
    // CKE history restarts low at reset; one edge records it high before a command
    settle(1);
    // RESET is a register write to address 0x3f: high address bits in the fall half are zero
    u_ctl.frame(1'b1, 1'b0, 10'h3f0, 10'h000);
    settle(2);
    `CHK("pw", PW_RESETTING, pw_state)
    u_ctl.frame(1'b0, 1'b1, 10'h000, 10'h000);
    settle(2);
    `CHK("pw", PW_RPD, pw_state)
    u_ctl.frame(1'b0, 1'b0, 10'h007, 10'h000);
    settle(2);
    `CHK("pw", PW_RPD, pw_state)
    u_ctl.frame(1'b1, 1'b1, 10'h000, 10'h000);
    settle(2);
    `CHK("pw", PW_RESETTING, pw_state)
    settle(45);
    `CHK("pw", PW_NORMAL, pw_state)
    `CHK("init", 1'b1, init_done)
    foreach (rows[i]) begin
      u_ctl.frame(1'b1, 1'b0, rows[i].r, rows[i].f);
      // Command report stands one cycle only; bank state is set on the same edge and checked a cycle later
      settle(1);
      `CHK("code", rows[i].c, cmd_evt.code)
      if (rows[i].c == CMD_RD) `CHK("col", 12'hffe, cmd_evt.col)
      settle(1);
      `CHK("bank", rows[i].s, bank_state[rows[i].b])
      settle(rows[i].g);
    end
    u_ctl.frame(1'b0, 1'b1, 10'h000, 10'h000);
    settle(2);
    `CHK("pw", PW_IPD, pw_state)
    u_ctl.frame(1'b0, 1'b0, 10'h007, 10'h000);
    settle(2);
    `CHK("pw", PW_IPD, pw_state)
    u_ctl.frame(1'b1, 1'b1, 10'h000, 10'h000);
    settle(2);
    `CHK("pw", PW_NORMAL, pw_state)
    u_ctl.frame(1'b1, 1'b0, 10'h282, 10'h000);
    u_ctl.frame(1'b0, 1'b1, 10'h000, 10'h000);
    settle(2);
    `CHK("pw", PW_APD, pw_state)
    u_ctl.frame(1'b1, 1'b1, 10'h000, 10'h000);
    settle(2);
    `CHK("pw", PW_NORMAL, pw_state)
    `CHK("bank", BK_ACT, bank_state[5])
    // Read on bank 5, terminated on the next edge, one edge before the burst would end
    u_ctl.frame(1'b1, 1'b0, 10'h285, 10'h000);
    u_ctl.frame(1'b1, 1'b0, 10'h003, 10'h000);
    settle(1);
    `CHK("code", CMD_BST, cmd_evt.code)
    `CHK("bank", BK_ACT, bank_state[5])
    `CHK("idle", 1'b0, all_idle)
    u_ctl.frame(1'b1, 1'b0, 10'h01b, 10'h000);
    settle(6);
    u_ctl.frame(1'b0, 1'b0, 10'h004, 10'h000);
    settle(2);
    `CHK("pw", PW_SREF, pw_state)
    u_ctl.frame(1'b1, 1'b1, 10'h000, 10'h000);
    settle(4);
    `CHK("pw", PW_NORMAL, pw_state)
    u_ctl.frame(1'b0, 1'b0, 10'h003, 10'h000);
    settle(2);
    `CHK("pw", PW_DPD, pw_state)
    u_ctl.frame(1'b1, 1'b1, 10'h000, 10'h000);
    settle(4);
    `CHK("pw", PW_POWERON, pw_state)
    `CHK("init", 1'b0, init_done)
    results();
  end
endmodule : lp2_cmd_power_state_fsm_tb
`default_nettype wire

//--- lp2_ctrl_model.sv
// Controller model driving clock enable, select and command/address pins
`timescale 1ns/1ps
`default_nettype none
module lp2_ctrl_model (
  input  wire logic       clk,
  output logic            cke,
  output logic            cs_n,
  output logic [9:0]      ca
);
  // Idle pins sit at defined levels, never floating
  initial begin
    cke  = 1'b1;
    cs_n = 1'b1;
    ca   = 10'h000;
  end
  // One frame: rise half held to its edge, fall half to the falling edge
  task automatic frame(input logic k, input logic c, input logic [9:0] r, input logic [9:0] f);
    cke  = k;
    cs_n = c;
    ca   = r;
    @(posedge clk);
    #1;
    ca   = f;
    cs_n = 1'b1;
    // Fall half stays on the pins: a defined level, and a back-to-back frame sets it only once
    @(negedge clk);
    #1;
  endtask : frame
endmodule : lp2_ctrl_model
`default_nettype wire

//--- lp2_params.svh
// Constants of the command and power state block: field positions, timing figures, counts
`ifndef LP2_PARAMS_SVH
`define LP2_PARAMS_SVH

// Core clock period in ns
`define LP2_CLK_PERIOD_NS 8

// Least time in ns to whole clock cycles, rounded up
`define LP2_NS_TO_CYC(ns) (((ns) + `LP2_CLK_PERIOD_NS - 1) / `LP2_CLK_PERIOD_NS)

// Busy times of the timed bank states and the final init wait, in ns
`define LP2_T_RP_NS 24
`define LP2_T_RFCPB_NS 96
`define LP2_T_RFCAB_NS 184
`define LP2_T_MRW_NS 40
`define LP2_T_MRR_NS 16
`define LP2_T_INIT5_NS 1000

// Data burst length in core clock cycles
`define LP2_BURST_CYC 2

// Bank count of the full configuration
`define LP2_NUM_BANKS 8

// Mode register address that turns a register write into RESET
`define LP2_MA_RESET 8'h3f

// Field positions in the rising half of the command/address bits
`define LP2_BA_LSB 7
`define LP2_AB_BIT 4

// Field positions in the falling half of the command/address bits
`define LP2_AP_BIT 0

`endif

//--- lp2_pkg.sv
// Types shared by the command capture and the command/power state machine
`default_nettype none

package lp2_pkg;

  // Global power state, one-hot
  typedef enum logic [7:0] {
    PW_POWERON   = 8'h01,
    PW_RESETTING = 8'h02,
    PW_NORMAL    = 8'h04,
    PW_APD       = 8'h08,
    PW_IPD       = 8'h10,
    PW_RPD       = 8'h20,
    PW_SREF      = 8'h40,
    PW_DPD       = 8'h80
  } lp2_pw_t;

  // Per-bank state, one-hot
  typedef enum logic [8:0] {
    BK_IDLE = 9'h001,
    BK_ACT  = 9'h002,
    BK_RD   = 9'h004,
    BK_WR   = 9'h008,
    BK_PRE  = 9'h010,
    BK_REF  = 9'h020,
    BK_MRW  = 9'h040,
    BK_MRRI = 9'h080,
    BK_MRRA = 9'h100
  } lp2_bank_t;

  // Decoded command codes
  typedef enum logic [3:0] {
    CMD_NONE  = 4'h0,
    CMD_NOP   = 4'h1,
    CMD_MRW   = 4'h2,
    CMD_MRR   = 4'h3,
    CMD_REFPB = 4'h4,
    CMD_REFAB = 4'h5,
    CMD_ACT   = 4'h6,
    CMD_WR    = 4'h7,
    CMD_RD    = 4'h8,
    CMD_PRE   = 4'h9,
    CMD_BST   = 4'ha,
    CMD_RESET = 4'hb,
    CMD_SREF  = 4'hc,
    CMD_DPD   = 4'hd,
    CMD_PDE   = 4'he,
    CMD_EXIT  = 4'hf
  } lp2_cmd_t;

  // One command frame as captured on the pins
  typedef struct packed {
    logic       cke_prev;
    logic       cke_cur;
    logic       cs_n;
    logic [9:0] ca_rise;
    logic [9:0] ca_fall;
  } lp2_frame_t;

  // Decoded command with its fields
  typedef struct packed {
    logic       valid;
    lp2_cmd_t   code;
    logic [2:0] bank;
    logic       ap;
    logic       ab;
    logic [14:0] row;
    logic [11:0] col;
    logic [7:0] ma;
    logic [7:0] op;
  } lp2_cmd_info_t;

endpackage : lp2_pkg

`default_nettype wire
